// ### rtl/tmr8_pkg.sv
// package of register map, field layout, reset values and state for the 8-bit timer
// Notes on behaviour
// RULE1: power-down bit one keeps timer disabled.
// RULE2: count and both compare values are 8-bit.
// RULE3: every request flagged, each gated by mask.
// RULE4: clock select zero stops the counter.
// RULE5: io clock default; crystal when async set.
// RULE6: bottom 0x00, max 0xff, top per mode.
// RULE7: each timer clock clears, increments or decrements.
// RULE8: cpu reads and writes count any time.
// RULE9: cpu write to count beats counting.
// RULE10: three-bit waveform mode split over controls.
// RULE11: overflow flag set at mode-dependent points.
// RULE12: match sets compare flag next timer clock.
// RULE13: flags cleared by acknowledge or writing one.
// RULE14: output from match, mode, output mode.
// RULE15: compare values double-buffered in pwm modes.
// RULE16: cpu reaches buffer when buffering active.
// RULE17: force strobe acts as match, no flag.
// RULE18: count write blocks next timer-clock match.
// RULE19: software avoids writing count equal compare.
// RULE20: software presets outputs before enabling pins.
// RULE21: output states kept across mode changes.
// RULE22: output mode writes take effect immediately.
// RULE23: mode zero counts up, overflow at wrap.
// RULE24: mode two clears on compare a match.
// RULE25: modes three, seven single-slope to top.
// RULE26: request only while flag and mask set.
package tmr8_pkg;

	// register byte offsets
	localparam logic [7:0] TMR8_OFS_CTRL_A  = 8'h00;
	localparam logic [7:0] TMR8_OFS_CTRL_B  = 8'h04;
	localparam logic [7:0] TMR8_OFS_COUNT   = 8'h08;
	localparam logic [7:0] TMR8_OFS_CMP_A   = 8'h0c;
	localparam logic [7:0] TMR8_OFS_CMP_B   = 8'h10;
	localparam logic [7:0] TMR8_OFS_FLAGS   = 8'h14;
	localparam logic [7:0] TMR8_OFS_MASK    = 8'h18;
	localparam logic [7:0] TMR8_OFS_ASYNC   = 8'h1c;
	localparam logic [7:0] TMR8_OFS_POWER   = 8'h20;

	// field positions
	localparam int TMR8_CA_WGM_LO   = 0;   // timer_control_a [1:0]
	localparam int TMR8_CA_COM_B    = 4;   // timer_control_a [5:4]
	localparam int TMR8_CA_COM_A    = 6;   // timer_control_a [7:6]
	localparam int TMR8_CB_CS       = 0;   // timer_control_b [2:0]
	localparam int TMR8_CB_WGM_HI   = 3;   // timer_control_b [3]
	localparam int TMR8_CB_FORCE_B  = 6;   // timer_control_b [6], strobe
	localparam int TMR8_CB_FORCE_A  = 7;   // timer_control_b [7], strobe
	localparam int TMR8_AS_SEL      = 5;   // async_status_register [5]
	localparam int TMR8_FL_OVF      = 0;   // flag and mask bit order
	localparam int TMR8_FL_CMP_A    = 1;
	localparam int TMR8_FL_CMP_B    = 2;

	// reset values and count limits
	localparam logic       TMR8_RST_POWER_DOWN = 1'b1;
	localparam logic [7:0] TMR8_RST_BYTE       = 8'h00;
	localparam logic [7:0] TMR8_BOTTOM         = 8'h00;
	localparam logic [7:0] TMR8_MAX            = 8'hff;

	// axi responses
	localparam logic [1:0] TMR8_RESP_OKAY   = 2'b00;
	localparam logic [1:0] TMR8_RESP_SLVERR = 2'b10;

	// waveform generation modes
	typedef enum logic [2:0] {
		TMR8_WGM_NORMAL   = 3'd0,
		TMR8_WGM_PC_MAX   = 3'd1,
		TMR8_WGM_CTC      = 3'd2,
		TMR8_WGM_FAST_MAX = 3'd3,
		TMR8_WGM_PC_CMPA  = 3'd5,
		TMR8_WGM_FAST_CMPA = 3'd7
	} tmr8_wgm_t;

	// whole state of the block, registered as one word
	typedef struct packed {
		logic       aw_got;      // write address held
		logic [7:0] aw_addr;
		logic       w_got;       // write data held
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] ctrl_a;
		logic [2:0] cs;
		logic       wgm_hi;
		logic       async_sel;
		logic       power_down;
		logic [7:0] count;
		logic       count_up;    // direction in phase-correct modes
		logic [7:0] cmp_a;       // active compare values
		logic [7:0] cmp_b;
		logic [7:0] buf_a;       // cpu-side buffers
		logic [7:0] buf_b;
		logic       block;       // match blocked for next timer clock
		logic [9:0] pre_cnt;     // prescaler
		logic       xtal_prev;   // last crystal sample
		logic       xtal_drive;
		logic [2:0] flags;
		logic [2:0] mask;
		logic [2:0] irq;
		logic       oc_a;
		logic       oc_b;
		logic       oe_a;
		logic       oe_b;
	} tmr8_state_t;

endpackage : tmr8_pkg

// ### rtl/tmr8_top.sv
// 8-bit timer/counter with two compare channels behind an axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
module tmr8_top
	import tmr8_pkg::*;
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	// axi4-lite write channels
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	// axi4-lite read channels
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	// interrupt requests and acknowledges, bit order ovf, cmp a, cmp b
	output logic [2:0]       o_irq,
	input  wire logic [2:0]  i_irq_ack,
	// crystal oscillator pins
	input  wire logic        i_crystal_pin_in,
	output logic             o_crystal_pin_out,
	// compare outputs and their port override enables
	output logic             o_compare_output_a,
	output logic             o_compare_output_b,
	output logic             o_compare_output_a_en,
	output logic             o_compare_output_b_en
);

	tmr8_state_t st_reg;   // present state
	tmr8_state_t st_next;  // next state

	// prescaler tap mask for a clock select value
	// the tick fires when every tapped bit of the free count is one
	function automatic logic [9:0] pre_mask(input logic [2:0] cs);
		unique case (cs)
			3'd1:    pre_mask = 10'h000;
			3'd2:    pre_mask = 10'h007;
			3'd3:    pre_mask = 10'h01f;
			3'd4:    pre_mask = 10'h03f;
			3'd5:    pre_mask = 10'h07f;
			3'd6:    pre_mask = 10'h0ff;
			3'd7:    pre_mask = 10'h3ff;
			default: pre_mask = 10'h000;
		endcase
	endfunction : pre_mask

	// next compare output state for one channel
	// hit is the unblocked match, wrap the restart at bottom
	// pwm output mode two is non-inverting, three inverting
	function automatic logic oc_step(input logic oc, input logic hit, input logic [1:0] com,
		input logic fast, input logic phase, input logic wrap, input logic up);
		oc_step = oc;
		if (fast) begin
			// set or clear at bottom, reversed on match
			if (hit && com == 2'd2) oc_step = 1'b0;
			if (hit && com == 2'd3) oc_step = 1'b1;
			if (wrap && com == 2'd2) oc_step = 1'b1;
			if (wrap && com == 2'd3) oc_step = 1'b0;
		end else if (phase) begin
			// match while up clears, while down sets (non-inverting)
			if (hit && com == 2'd2) oc_step = ~up;
			if (hit && com == 2'd3) oc_step = up;
		end else if (hit) begin
			// non-pwm: toggle, clear or set
			unique case (com)
				2'd1:    oc_step = ~oc;
				2'd2:    oc_step = 1'b0;
				2'd3:    oc_step = 1'b1;
				default: oc_step = oc;
			endcase
		end
	endfunction : oc_step

	// register read mux
	// strobes and unused bits read back as zero
	function automatic logic [31:0] rd_mux(input tmr8_state_t s, input logic [7:0] a, input logic pwm);
		rd_mux = 32'h0000_0000;
		unique case (a)
			TMR8_OFS_CTRL_A: rd_mux[7:0] = s.ctrl_a;
			TMR8_OFS_CTRL_B: rd_mux[7:0] = {4'h0, s.wgm_hi, s.cs};
			TMR8_OFS_COUNT:  rd_mux[7:0] = s.count;
			TMR8_OFS_CMP_A:  rd_mux[7:0] = pwm ? s.buf_a : s.cmp_a;
			TMR8_OFS_CMP_B:  rd_mux[7:0] = pwm ? s.buf_b : s.cmp_b;
			TMR8_OFS_FLAGS:  rd_mux[2:0] = s.flags;
			TMR8_OFS_MASK:   rd_mux[2:0] = s.mask;
			TMR8_OFS_ASYNC:  rd_mux[TMR8_AS_SEL] = s.async_sel;
			TMR8_OFS_POWER:  rd_mux[0] = s.power_down;
			default:         rd_mux = 32'h0000_0000;
		endcase
	endfunction : rd_mux

	// address decode shared by read and write paths
	// refuses unaligned and out-of-range byte addresses
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a <= TMR8_OFS_POWER);
	endfunction : is_mapped

	// next state: bus slave, prescaler, counter, compare and waveform
	always_comb begin
		logic [2:0]  wgm;
		logic        fast;
		logic        phase;
		logic        ctc;
		logic        pwm;
		logic        src;
		logic        tick;
		logic [7:0]  top;
		logic        eq_a;
		logic        eq_b;
		logic        hit_a;
		logic        hit_b;
		logic        wrap;
		logic        at_top;
		logic [2:0]  fl_set;
		logic [2:0]  fl_clr;
		logic        do_wr;
		logic [7:0]  wb;
		// every local gets a value first, so none is held over
		st_next = st_reg;
		src     = 1'b0;
		eq_a    = 1'b0;
		eq_b    = 1'b0;
		wgm     = {st_reg.wgm_hi, st_reg.ctrl_a[TMR8_CA_WGM_LO +: 2]};  // RULE10
		fast    = (wgm[1:0] == 2'd3);
		phase   = (wgm[1:0] == 2'd1);
		ctc     = (wgm == TMR8_WGM_CTC);
		pwm     = fast || phase;
		top     = wgm[2] ? st_reg.cmp_a : TMR8_MAX;  // RULE6 RULE25
		fl_set  = 3'b000;
		fl_clr  = i_irq_ack;  // RULE13
		wrap    = 1'b0;
		at_top  = 1'b0;
		hit_a   = 1'b0;
		hit_b   = 1'b0;
		do_wr   = 1'b0;
		wb      = 8'h00;

		// timer clock source: io clock or rising crystal edge, then prescaler
		// hazard: crystal pulses shorter than one clock are lost
		// a stopped or powered-down timer also restarts its prescaler
		st_next.xtal_prev  = i_crystal_pin_in;
		st_next.xtal_drive = st_reg.async_sel & ~i_crystal_pin_in;
		src  = st_reg.async_sel ? (i_crystal_pin_in & ~st_reg.xtal_prev) : 1'b1;  // RULE5
		tick = 1'b0;
		if (st_reg.power_down || st_reg.cs == 3'd0) begin
			st_next.pre_cnt = 10'h000;  // RULE1 RULE4
		end else if (src) begin
			tick = ((st_reg.pre_cnt & pre_mask(st_reg.cs)) == pre_mask(st_reg.cs));
			st_next.pre_cnt = st_reg.pre_cnt + 10'h001;
		end

		// continuous comparison on 8-bit values, also while stopped
		// the result is only acted on at a timer clock
		eq_a = (st_reg.count == st_reg.cmp_a);  // RULE2
		eq_b = (st_reg.count == st_reg.cmp_b);

		// one timer clock step
		// flags set one timer clock after equality is seen
		// a count write before this step cancels both matches once
		if (tick) begin
			hit_a = eq_a && !st_reg.block;  // RULE18
			hit_b = eq_b && !st_reg.block;  // RULE18
			st_next.block = 1'b0;
			fl_set[TMR8_FL_CMP_A] = hit_a;  // RULE12
			fl_set[TMR8_FL_CMP_B] = hit_b;  // RULE12
			if (fast) begin
				// single slope, restart at bottom after top
				// top is max or compare a, picked by the high mode bit
				wrap = (st_reg.count == top);  // RULE25
				st_next.count = wrap ? TMR8_BOTTOM : st_reg.count + 8'h01;  // RULE7
				fl_set[TMR8_FL_OVF] = wrap;  // RULE11
			end else if (phase) begin
				// dual slope, turn at top and bottom
				// direction flips at the turns, overflow at the bottom turn
				if (st_reg.count_up) begin
					at_top = (st_reg.count == top);
					st_next.count_up = ~at_top;
					st_next.count = at_top ? st_reg.count - 8'h01 : st_reg.count + 8'h01;  // RULE7
				end else begin
					wrap = (st_reg.count == TMR8_BOTTOM);
					st_next.count_up = wrap;
					st_next.count = wrap ? st_reg.count + 8'h01 : st_reg.count - 8'h01;
					fl_set[TMR8_FL_OVF] = wrap;  // RULE11
				end
			end else if (ctc && hit_a) begin
				// unbuffered: a compare value below count waits for the wrap
				st_next.count = TMR8_BOTTOM;  // RULE24
			end else begin
				// normal and ctc below top: count up, overflow wrapping max
				st_next.count = st_reg.count + 8'h01;  // RULE23
				fl_set[TMR8_FL_OVF] = (st_reg.count == TMR8_MAX);  // RULE11 RULE23
			end
			// buffered compare values move at bottom (fast) or top (phase)
			// this keeps pwm pulses whole when software changes a value
			if ((fast && wrap) || (phase && at_top)) begin
				st_next.cmp_a = st_reg.buf_a;  // RULE15
				st_next.cmp_b = st_reg.buf_b;  // RULE15
			end
			// waveform generator
			st_next.oc_a = oc_step(st_reg.oc_a, hit_a, st_reg.ctrl_a[TMR8_CA_COM_A +: 2], fast, phase, wrap,
				st_reg.count_up);  // RULE14
			st_next.oc_b = oc_step(st_reg.oc_b, hit_b, st_reg.ctrl_a[TMR8_CA_COM_B +: 2], fast, phase, wrap,
				st_reg.count_up);  // RULE14
		end

		// axi write address and data, taken in either order
		// a waiting response holds off new address and data items
		// unmapped or unaligned writes are still answered
		if (i_s_axi_awvalid && st_reg.awready) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && st_reg.wready) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = i_s_axi_wdata;
			st_next.w_strb = i_s_axi_wstrb;
		end
		if (st_reg.bvalid && i_s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = is_mapped(st_reg.aw_addr) ? TMR8_RESP_OKAY : TMR8_RESP_SLVERR;
			do_wr = st_reg.w_strb[0];
			wb    = st_reg.w_data[7:0];
		end

		// register write effects, applied after counting so the cpu wins
		// a write with the low strobe clear is answered but stores nothing
		if (do_wr) begin
			unique case (st_reg.aw_addr)
				TMR8_OFS_CTRL_A: st_next.ctrl_a = wb;  // RULE21 RULE22
				TMR8_OFS_CTRL_B: begin
					st_next.cs     = wb[TMR8_CB_CS +: 3];
					st_next.wgm_hi = wb[TMR8_CB_WGM_HI];
					// force strobes act only outside pwm modes, no flag, no count change
					// they are never stored, so they read back as zero
					if (!pwm && wb[TMR8_CB_FORCE_A]) begin
						st_next.oc_a = oc_step(st_reg.oc_a, 1'b1, st_reg.ctrl_a[TMR8_CA_COM_A +: 2], 1'b0, 1'b0,
							1'b0, 1'b1);  // RULE17
					end
					if (!pwm && wb[TMR8_CB_FORCE_B]) begin
						st_next.oc_b = oc_step(st_reg.oc_b, 1'b1, st_reg.ctrl_a[TMR8_CA_COM_B +: 2], 1'b0, 1'b0,
							1'b0, 1'b1);  // RULE17
					end
				end
				TMR8_OFS_COUNT: begin
					// cpu write also arms the match block
					st_next.count = wb;  // RULE8 RULE9
					st_next.block = 1'b1;  // RULE18
				end
				TMR8_OFS_CMP_A: begin
					st_next.buf_a = wb;  // RULE16
					if (!pwm) st_next.cmp_a = wb;  // RULE15 RULE16
				end
				TMR8_OFS_CMP_B: begin
					st_next.buf_b = wb;  // RULE16
					if (!pwm) st_next.cmp_b = wb;  // RULE15 RULE16
				end
				TMR8_OFS_FLAGS: fl_clr = fl_clr | wb[2:0];  // RULE13
				TMR8_OFS_MASK:  st_next.mask = wb[2:0];  // RULE3
				TMR8_OFS_ASYNC: st_next.async_sel = wb[TMR8_AS_SEL];  // RULE5
				TMR8_OFS_POWER: st_next.power_down = wb[0];  // RULE1
				default: ;  // unmapped: nothing stored
			endcase
		end
		// ready drops once an item is held or a response waits
		st_next.awready = ~st_next.aw_got & ~st_next.bvalid;
		st_next.wready  = ~st_next.w_got & ~st_next.bvalid;

		// flags: a setting event wins over a clear in the same cycle
		// the request is registered from the new flags and mask, so it changes with them
		st_next.flags = (st_reg.flags & ~fl_clr) | fl_set;  // RULE3 RULE12
		st_next.irq   = st_next.flags & st_next.mask;  // RULE26

		// port override enables follow output mode at once
		// they use the new output mode, so a write acts without delay
		st_next.oe_a = (st_next.ctrl_a[TMR8_CA_COM_A +: 2] != 2'd0);  // RULE22
		st_next.oe_b = (st_next.ctrl_a[TMR8_CA_COM_B +: 2] != 2'd0);  // RULE22

		// axi read: one outstanding, answer one cycle after address taken
		// read data is captured at the address edge and held to rready
		if (st_reg.rvalid && i_s_axi_rready) begin
			st_next.rvalid  = 1'b0;
			st_next.arready = 1'b1;
		end
		if (i_s_axi_arvalid && st_reg.arready) begin
			st_next.arready = 1'b0;
			st_next.rvalid  = 1'b1;
			st_next.rdata   = rd_mux(st_reg, i_s_axi_araddr, pwm);
			st_next.rresp   = is_mapped(i_s_axi_araddr) ? TMR8_RESP_OKAY : TMR8_RESP_SLVERR;
		end
	end

	// state register, cleared to constants by reset
	// the timer starts powered down, so software must enable it
	// ready signals start high so the first request is taken at once
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg            <= '0;
			st_reg.awready    <= 1'b1;
			st_reg.wready     <= 1'b1;
			st_reg.arready    <= 1'b1;
			st_reg.count_up   <= 1'b1;
			st_reg.power_down <= TMR8_RST_POWER_DOWN;  // RULE1
			st_reg.count      <= TMR8_RST_BYTE;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	// no logic stands between the state register and the pins
	assign o_s_axi_awready       = st_reg.awready;
	assign o_s_axi_wready        = st_reg.wready;
	assign o_s_axi_bresp         = st_reg.bresp;
	assign o_s_axi_bvalid        = st_reg.bvalid;
	assign o_s_axi_arready       = st_reg.arready;
	assign o_s_axi_rdata         = st_reg.rdata;
	assign o_s_axi_rresp         = st_reg.rresp;
	assign o_s_axi_rvalid        = st_reg.rvalid;
	assign o_irq                 = st_reg.irq;
	assign o_crystal_pin_out     = st_reg.xtal_drive;
	assign o_compare_output_a    = st_reg.oc_a;
	assign o_compare_output_b    = st_reg.oc_b;
	assign o_compare_output_a_en = st_reg.oe_a;
	assign o_compare_output_b_en = st_reg.oe_b;

endmodule : tmr8_top
`default_nettype wire

// ### dv/tmr8_props.sv
// assertion checker for the timer's bus handshakes and interrupt lines
`timescale 1ns/1ns
`default_nettype none
module tmr8_props
	import tmr8_pkg::*;
(
	// clock and reset
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	// write channels
	input wire logic [7:0]  i_s_axi_awaddr,
	input wire logic        i_s_axi_awvalid,
	input wire logic        o_s_axi_awready,
	input wire logic        i_s_axi_wvalid,
	input wire logic        o_s_axi_wready,
	input wire logic [1:0]  o_s_axi_bresp,
	input wire logic        o_s_axi_bvalid,
	input wire logic        i_s_axi_bready,
	// read channels
	input wire logic [7:0]  i_s_axi_araddr,
	input wire logic        i_s_axi_arvalid,
	input wire logic        o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0]  o_s_axi_rresp,
	input wire logic        o_s_axi_rvalid,
	input wire logic        i_s_axi_rready,
	// interrupt lines
	input wire logic [2:0]  o_irq,
	input wire logic [2:0]  i_irq_ack
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	logic       w_take;     // both write items taken at this edge
	logic       w_bad;      // write address unmapped or unaligned
	logic       ar_take;    // read address taken at this edge
	logic [2:0] hist_reg;   // recent acknowledges or write responses
	logic [2:0] hist_next;
	assign w_take  = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
	assign w_bad   = i_s_axi_awaddr > TMR8_OFS_POWER || i_s_axi_awaddr[1:0] != 2'b00;
	assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
	// remembers any event that may clear a flag or a mask bit
	always_comb hist_next = {hist_reg[1:0], (|i_irq_ack) || o_s_axi_bvalid};
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst)
			hist_reg <= 3'h0;
		else
			hist_reg <= hist_next;
	end
	w_resp_a: assert property (w_take |-> ##[1:2] o_s_axi_bvalid) else $error("write got no response");
	w_okay_a: assert property (w_take && !w_bad |-> ##[1:2] (o_s_axi_bvalid && o_s_axi_bresp == TMR8_RESP_OKAY))
		else $error("mapped write not answered okay");
	w_err_a: assert property (w_take && w_bad |-> ##[1:2] (o_s_axi_bvalid && o_s_axi_bresp == TMR8_RESP_SLVERR))
		else $error("unmapped write not refused");
	r_err_a: assert property (ar_take && i_s_axi_araddr > TMR8_OFS_POWER |=>
		o_s_axi_rvalid && o_s_axi_rresp == TMR8_RESP_SLVERR && o_s_axi_rdata == 32'h0) else $error("bad read answer");
	r_resp_a: assert property (ar_take |=> o_s_axi_rvalid && !o_s_axi_arready) else $error("read not answered");
	b_busy_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write ready during response");
	b_done_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid) else $error("response stuck");
	r_done_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid && o_s_axi_arready)
		else $error("read data stuck");
	r_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
	irq_drop_a: assert property (|(~o_irq & $past(o_irq)) |-> (|hist_reg || o_s_axi_bvalid))
		else $error("interrupt dropped without cause");
	cover property (|(~o_irq & $past(o_irq)));
	cover property (o_s_axi_bvalid && o_s_axi_bresp == TMR8_RESP_SLVERR);
	cover property (o_irq[1]);
endmodule : tmr8_props
bind tmr8_top tmr8_props tmr8_props_inst (.i_mclk, .i_nrst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
	.i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
	.i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
	.o_irq, .i_irq_ack);
`default_nettype wire

// ### dv/tmr8_top_test.sv
// self-checking bench for the 8-bit timer: bus, counting, flags, compare outputs
`timescale 1ns/1ns
`default_nettype none
module tmr8_top_test;
	import tmr8_pkg::*;
	logic        clk, nrst;          // clock and active-low reset
	logic [7:0]  awa, ara;           // write and read addresses
	logic        awv, wv, arv, xtal; // request valids and crystal pin
	logic [31:0] wd, rdat, q;        // write data, read data, last read
	logic [2:0]  ack, irq;           // acknowledges and requests
	logic [1:0]  bresp, rresp, r;    // responses and last response
	logic        awr, wrr, arr, bv, rv, oa, ob, ena, enb, old, xo;
	int          err_total, tests_run, cyc;
	tmr8_top tmr8_top_inst (.i_mclk(clk), .i_nrst(nrst), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
		.o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
		.o_s_axi_wready(wrr), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(1'b1),
		.i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdat),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(1'b1), .o_irq(irq), .i_irq_ack(ack),
		.i_crystal_pin_in(xtal), .o_crystal_pin_out(xo), .o_compare_output_a(oa), .o_compare_output_b(ob),
		.o_compare_output_a_en(ena), .o_compare_output_b_en(enb));
	// free-running clock at 20 MHz
	initial clk = 1'b0;
	always #25 clk = ~clk;
	// hang guard: the whole run needs a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			results();
		end
	end
	// verdict and end of run
	task results;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// bus write: both items offered, each released when taken, then the response
	task wr(input logic [7:0] a, input logic [7:0] v);
		awa <= a;
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrr) wv <= 1'b0;
		end while ((awv && !awr) || (wv && !wrr));
		do @(posedge clk); while (bv !== 1'b1);
		r = bresp;
	endtask : wr
	// bus read into q and r
	task rd(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		q = rdat;
		r = rresp;
	endtask : rd
	// reset values, power-down, stopped counter, unmapped place
	task s_reset;
		rd(TMR8_OFS_POWER);
		chk(q, 32'h1);
		wr(TMR8_OFS_CTRL_B, 8'h01);
		tick(20);
		rd(TMR8_OFS_COUNT);
		chk(q, 32'h0);
		wr(TMR8_OFS_POWER, 8'h00);
		wr(TMR8_OFS_CTRL_B, 8'h00);
		wr(TMR8_OFS_COUNT, 8'h42);
		tick(20);
		rd(TMR8_OFS_COUNT);
		chk(q, 32'h42);
		rd(8'h24);
		chk(32'(r), 32'(TMR8_RESP_SLVERR));
		wr(8'h24, 8'h11);
		chk(32'(r), 32'(TMR8_RESP_SLVERR));
	endtask : s_reset
	// normal-mode wrap, mask gating, acknowledge
	task s_ovf;
		int n;
		n = 0;
		wr(TMR8_OFS_CTRL_A, 8'h00);
		wr(TMR8_OFS_COUNT, 8'hf0);
		wr(TMR8_OFS_FLAGS, 8'h07);
		wr(TMR8_OFS_MASK, 8'h01);
		wr(TMR8_OFS_CTRL_B, 8'h01);
		while (irq[0] !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		wr(TMR8_OFS_CTRL_B, 8'h00);
		rd(TMR8_OFS_FLAGS);
		chk(32'(q[0]), 32'h1);
		wr(TMR8_OFS_MASK, 8'h00);
		tick(2);
		chk(32'(irq), 32'h0);
		wr(TMR8_OFS_MASK, 8'h01);
		tick(2);
		chk(32'(irq), 32'h1);
		ack <= 3'b001;
		tick(1);
		ack <= 3'b000;
		tick(2);
		chk(32'(irq), 32'h0);
	endtask : s_ovf
	// clear on compare a match
	task s_ctc;
		wr(TMR8_OFS_CTRL_A, 8'h02);
		wr(TMR8_OFS_CMP_A, 8'h10);
		wr(TMR8_OFS_COUNT, 8'h00);
		wr(TMR8_OFS_FLAGS, 8'h07);
		wr(TMR8_OFS_MASK, 8'h02);
		wr(TMR8_OFS_CTRL_B, 8'h01);
		tick(60);
		wr(TMR8_OFS_CTRL_B, 8'h00);
		rd(TMR8_OFS_COUNT);
		chk(32'(q <= 32'h10), 32'h1);
		chk(32'(irq), 32'h2);
		wr(TMR8_OFS_FLAGS, 8'h02);
		tick(2);
		chk(32'(irq), 32'h0);
	endtask : s_ctc
	// count write blocks the next match; pwm buffer holds a new compare value
	task s_block;
		wr(TMR8_OFS_CTRL_A, 8'h00);
		wr(TMR8_OFS_CMP_B, 8'h05);
		for (int v = 4; v < 6; v++) begin
			wr(TMR8_OFS_COUNT, 8'(v));
			wr(TMR8_OFS_FLAGS, 8'h07);
			wr(TMR8_OFS_CTRL_B, 8'h01);
			wr(TMR8_OFS_CTRL_B, 8'h00);
			rd(TMR8_OFS_FLAGS);
			chk(32'(q[2]), 32'(v == 4));
		end
		wr(TMR8_OFS_CTRL_A, 8'h03);
		wr(TMR8_OFS_CMP_B, 8'h80);
		wr(TMR8_OFS_COUNT, 8'h03);
		wr(TMR8_OFS_FLAGS, 8'h07);
		wr(TMR8_OFS_CTRL_B, 8'h01);
		tick(3);
		wr(TMR8_OFS_CTRL_B, 8'h00);
		rd(TMR8_OFS_CMP_B);
		chk(q, 32'h80);
		rd(TMR8_OFS_FLAGS);
		chk(32'(q[2]), 32'h1);
	endtask : s_block
	// force strobe toggles output a; output mode and state across mode change
	task s_force;
		logic [31:0] cnt;
		wr(TMR8_OFS_CTRL_A, 8'h70);
		tick(2);
		chk(32'(ena), 32'h1);
		chk(32'(enb), 32'h1);
		old = oa;
		rd(TMR8_OFS_COUNT);
		cnt = q;
		wr(TMR8_OFS_CTRL_B, 8'hc0);
		tick(2);
		chk(32'(oa), 32'(!old));
		chk(32'(ob), 32'h1);
		rd(TMR8_OFS_COUNT);
		chk(q, cnt);
		rd(TMR8_OFS_FLAGS);
		chk(32'(q[1]), 32'h0);
		wr(TMR8_OFS_CTRL_A, 8'h73);
		tick(2);
		chk(32'(oa), 32'(!old));
		chk(32'(ob), 32'h1);
		wr(TMR8_OFS_CTRL_A, 8'h00);
		tick(2);
		chk(32'(ena), 32'h0);
		chk(32'(enb), 32'h0);
	endtask : s_force
	// crystal edges count the timer when async clock is selected
	task s_async;
		wr(TMR8_OFS_ASYNC, 8'h20);
		wr(TMR8_OFS_COUNT, 8'h00);
		wr(TMR8_OFS_CTRL_B, 8'h01);
		tick(10);
		repeat (10) begin
			xtal <= 1'b1;
			tick(4);
			chk(32'(xo), 32'h0);
			xtal <= 1'b0;
			tick(4);
		end
		chk(32'(xo), 32'h1);
		wr(TMR8_OFS_CTRL_B, 8'h00);
		rd(TMR8_OFS_COUNT);
		chk(q, 32'h0a);
		wr(TMR8_OFS_ASYNC, 8'h00);
	endtask : s_async
	// main sequence
	initial begin
		{nrst, awv, wv, arv, xtal, ack} = '0;
		{awa, ara, wd} = '0;
		{err_total, tests_run, cyc} = '0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		s_reset();
		s_ovf();
		s_ctc();
		s_block();
		s_force();
		s_async();
		results();
	end
endmodule : tmr8_top_test
`default_nettype wire
